// File: hdl/pbq_pkg.sv
// Shared constants for the packet buffer queue manager.
package pbq_pkg;
  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int          PKT_W       = 6;
  localparam int          NUM_PKTS    = 64;
  localparam int          PAGE_W      = 4;
  localparam int          FREE_W      = 10;
  localparam int          BYTES_W     = 11;
  localparam int          OFF_W       = 10;
  localparam int          ADDR_W      = 15;
  localparam int          DATA_W      = 32;
  localparam int          STAT_W      = 16;
  localparam int          PAGE_SHIFT  = 8;
  localparam int          SLOT_W      = 9;
  // ---------------------------------------------------------------------------
  // Values
  // ---------------------------------------------------------------------------
  localparam logic [FREE_W-1:0]  TOTAL_PAGES  = 10'h200;
  localparam logic [11:0]        PAGE_ROUND   = 12'h0ff;
  localparam logic [OFF_W-1:0]   RX_FIRST_OFF = 10'h002;
  localparam logic [SLOT_W-1:0]  STAT_WORD    = 9'h000;
  localparam logic [SLOT_W-1:0]  COUNT_WORD   = 9'h001;
  localparam logic [PAGE_W-1:0]  ONE_PAGE     = 4'h1;
  localparam logic [PAGE_W-1:0]  NO_PAGES     = 4'h0;
endpackage

// File: hdl/pkt_queue.sv
// Packet number queue whose storage is a small memory with a registered head.
`timescale 1ns/1ps
module pkt_queue #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 64
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] head,
  output logic                  empty
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW-1:0]    rd_ptr_d;
  logic [AW:0]      count_q;
  logic             do_pop;
  logic             do_push;

  // Popping an empty queue or pushing a full one is ignored.
  assign do_pop   = pop && (count_q != '0);
  assign do_push  = push && (count_q != DEPTH[AW:0]);
  assign rd_ptr_d = do_pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
  assign empty    = (count_q == '0);

  always_ff @(posedge clk_sys) begin
    if (clk_en && do_push) begin
      mem_q[wr_ptr_q] <= push_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else if (clk_en) begin
      wr_ptr_q <= do_push ? wr_ptr_q + 1'b1 : wr_ptr_q;
      rd_ptr_q <= rd_ptr_d;
      count_q  <= count_q + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
    end
  end

  // The head is bypassed from the write port when it lands in the slot being read.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      head <= '0;
    end else if (clk_en) begin
      head <= (do_push && wr_ptr_q == rd_ptr_d) ? push_data : mem_q[rd_ptr_d];
    end
  end
endmodule

// File: hdl/packet_buffer_queue_manager.sv
// Buffer page allocator, packet numbering and transmit/receive queue logic.
`timescale 1ns/1ps
module packet_buffer_queue_manager (
  input  wire logic                          clk_sys,
  input  wire logic                          reset_n,
  input  wire logic                          clk_en,
  // Host commands and configuration.
  input  wire logic                          cmd_alloc_tx,
  input  wire logic [pbq_pkg::BYTES_W-1:0]   alloc_bytes,
  input  wire logic                          alloc_done_clr,
  input  wire logic [pbq_pkg::PKT_W-1:0]     packet_number_reg,
  input  wire logic                          cmd_enqueue_tx,
  input  wire logic                          cmd_release,
  input  wire logic                          cmd_rx_pop_release,
  input  wire logic                          tx_int_ack,
  input  wire logic                          tx_enable_bit,
  input  wire logic                          rx_enable_bit,
  input  wire logic                          rx_int_enable,
  input  wire logic                          auto_release,
  input  wire logic                          full_duplex,
  input  wire logic [pbq_pkg::FREE_W-1:0]    reserved_pages,
  output logic                               alloc_done_flag,
  output logic                               alloc_pending,
  output logic      [pbq_pkg::PKT_W-1:0]     alloc_result,
  output logic      [pbq_pkg::PKT_W-1:0]     tx_done_pkt,
  output logic      [pbq_pkg::PKT_W-1:0]     rx_head_pkt,
  output logic                               tx_int_flag,
  output logic                               tx_empty_flag,
  output logic                               rx_pending_flag,
  output logic      [pbq_pkg::FREE_W-1:0]    free_pages,
  output logic      [pbq_pkg::FREE_W-1:0]    mem_pages,
  // MAC transmit engine.
  input  wire logic                          defer_ok,
  input  wire logic                          tx_done,
  input  wire logic                          tx_ok,
  input  wire logic                          tx_fatal,
  input  wire logic [pbq_pkg::STAT_W-1:0]    tx_status,
  output logic                               tx_start,
  output logic      [pbq_pkg::PKT_W-1:0]     tx_pkt,
  // MAC receive engine.
  input  wire logic                          rx_frame_start,
  input  wire logic                          rx_word_valid,
  input  wire logic [pbq_pkg::DATA_W-1:0]    rx_word,
  input  wire logic                          rx_overrun,
  input  wire logic                          rx_end,
  input  wire logic                          rx_crc_ok,
  input  wire logic [pbq_pkg::STAT_W-1:0]    rx_status,
  input  wire logic [pbq_pkg::BYTES_W-1:0]   rx_byte_count,
  output logic                               rx_dropped,
  // Packet memory write port.
  output logic                               mem_we,
  output logic      [pbq_pkg::ADDR_W-1:0]    mem_addr,
  output logic      [pbq_pkg::DATA_W-1:0]    mem_wdata
);
  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {TX_IDLE, TX_BUSY, TX_STATUS} tx_state_e;
  typedef enum logic [2:0] {RX_IDLE, RX_DATA, RX_STAT, RX_COUNT, RX_DROP} rx_state_e;

  tx_state_e                       tx_state_q;
  rx_state_e                       rx_state_q;
  logic [pbq_pkg::PAGE_W-1:0]      pages_q [pbq_pkg::NUM_PKTS];
  logic [pbq_pkg::FREE_W-1:0]      free_q;
  logic [pbq_pkg::BYTES_W-1:0]     alloc_bytes_q;
  logic [pbq_pkg::PKT_W-1:0]       rx_pkt_q;
  logic [pbq_pkg::OFF_W-1:0]       rx_off_q;
  logic                            rx_crc_q;
  logic [pbq_pkg::STAT_W-1:0]      rx_stat_q;
  logic [pbq_pkg::BYTES_W-1:0]     rx_cnt_q;
  logic                            tx_ok_q;
  logic                            tx_fatal_q;
  logic [pbq_pkg::STAT_W-1:0]      tx_stat_q;
  logic [pbq_pkg::PKT_W-1:0]       free_num;
  logic                            free_num_ok;
  logic [11:0]                     tx_need_wide;
  logic [pbq_pkg::PAGE_W-1:0]      tx_need;
  logic                            rx_new_ok;
  logic                            rx_grow;
  logic                            rx_grow_ok;
  logic                            rx_drop_now;
  logic                            rx_wr;
  logic                            rx_release;
  logic                            tx_grant;
  logic                            tx_wr;
  logic                            auto_free;
  logic                            txq_empty;
  logic                            doneq_empty;
  logic                            rxq_empty;
  logic                            doneq_push;
  logic [pbq_pkg::FREE_W-1:0]      taken;
  logic [pbq_pkg::FREE_W-1:0]      returned;

  // ---------------------------------------------------------------------------
  // Queues
  // ---------------------------------------------------------------------------
  pkt_queue #(.WIDTH(pbq_pkg::PKT_W), .DEPTH(pbq_pkg::NUM_PKTS)) u_tx_queue (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .push      (cmd_enqueue_tx),
    .push_data (packet_number_reg),
    .pop       (tx_wr),
    .head      (tx_pkt),
    .empty     (txq_empty)
  );

  pkt_queue #(.WIDTH(pbq_pkg::PKT_W), .DEPTH(pbq_pkg::NUM_PKTS)) u_done_queue (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .push      (doneq_push),
    .push_data (tx_pkt),
    .pop       (tx_int_ack),
    .head      (tx_done_pkt),
    .empty     (doneq_empty)
  );

  pkt_queue #(.WIDTH(pbq_pkg::PKT_W), .DEPTH(pbq_pkg::NUM_PKTS)) u_rx_queue (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .push      (rx_state_q == RX_COUNT && rx_crc_q),
    .push_data (rx_pkt_q),
    .pop       (cmd_rx_pop_release),
    .head      (rx_head_pkt),
    .empty     (rxq_empty)
  );

  assign tx_int_flag     = !doneq_empty;
  assign tx_empty_flag   = txq_empty;
  assign rx_pending_flag = !rxq_empty && rx_int_enable;
  assign free_pages      = free_q;
  assign mem_pages       = pbq_pkg::TOTAL_PAGES;

  // ---------------------------------------------------------------------------
  // Allocator
  // ---------------------------------------------------------------------------
  // Lowest unused packet number; a number is in use while it owns pages.
  always_comb begin
    free_num    = '0;
    free_num_ok = 1'b0;
    for (int i = pbq_pkg::NUM_PKTS - 1; i >= 0; i--) begin
      if (pages_q[i] == pbq_pkg::NO_PAGES) begin
        free_num    = i[pbq_pkg::PKT_W-1:0];
        free_num_ok = 1'b1;
      end
    end
  end

  // A zero reserve leaves the whole memory first-come first-served.
  assign rx_new_ok = rx_frame_start && rx_enable_bit && rx_state_q == RX_IDLE
                     && free_num_ok && (free_q > reserved_pages);
  // Growth of a frame already admitted needs a free page and an offset below 512, whatever the reserve.
  assign rx_grow    = rx_state_q == RX_DATA && rx_word_valid && rx_off_q[5:0] == 6'h00;
  // An overrun in the growth cycle must not add a page to a frame that is being freed.
  assign rx_grow_ok = rx_grow && !rx_off_q[pbq_pkg::OFF_W-1] && !rx_overrun
                      && free_q != '0;
  assign rx_drop_now = rx_state_q == RX_DATA
                       && (rx_overrun || (rx_grow && !rx_grow_ok));
  assign rx_release  = rx_drop_now || (rx_state_q == RX_COUNT && !rx_crc_q);

  assign tx_need_wide = ({1'b0, alloc_bytes_q} + pbq_pkg::PAGE_ROUND) >> pbq_pkg::PAGE_SHIFT;
  assign tx_need      = tx_need_wide[pbq_pkg::PAGE_W-1:0];
  // The receive side wins a same-cycle contest; the host request simply waits.
  assign tx_grant = alloc_pending && !rx_new_ok && !rx_grow && free_num_ok
                    && free_q >= {6'h00, tx_need};

  assign auto_free  = tx_wr && tx_ok_q && !tx_fatal_q && auto_release;
  assign doneq_push = tx_wr && !auto_free;

  always_comb begin
    taken = '0;
    if (rx_new_ok || rx_grow_ok) begin
      taken = {6'h00, pbq_pkg::ONE_PAGE};
    end else if (tx_grant) begin
      taken = {6'h00, tx_need};
    end
  end

  always_comb begin
    returned = '0;
    if (cmd_release) begin
      returned = returned + {6'h00, pages_q[packet_number_reg]};
    end
    if (cmd_rx_pop_release && !rxq_empty) begin
      returned = returned + {6'h00, pages_q[rx_head_pkt]};
    end
    if (auto_free) begin
      returned = returned + {6'h00, pages_q[tx_pkt]};
    end
    if (rx_release) begin
      returned = returned + {6'h00, pages_q[rx_pkt_q]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      free_q <= pbq_pkg::TOTAL_PAGES;
    end else if (clk_en) begin
      free_q <= free_q + returned - taken;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      for (int i = 0; i < pbq_pkg::NUM_PKTS; i++) begin
        pages_q[i] <= pbq_pkg::NO_PAGES;
      end
    end else if (clk_en) begin
      if (cmd_release) begin
        pages_q[packet_number_reg] <= pbq_pkg::NO_PAGES;
      end
      if (cmd_rx_pop_release && !rxq_empty) begin
        pages_q[rx_head_pkt] <= pbq_pkg::NO_PAGES;
      end
      if (auto_free) begin
        pages_q[tx_pkt] <= pbq_pkg::NO_PAGES;
      end
      if (rx_release) begin
        pages_q[rx_pkt_q] <= pbq_pkg::NO_PAGES;
      end
      if (rx_grow_ok) begin
        pages_q[rx_pkt_q] <= pages_q[rx_pkt_q] + pbq_pkg::ONE_PAGE;
      end
      if (rx_new_ok) begin
        pages_q[free_num] <= pbq_pkg::ONE_PAGE;
      end else if (tx_grant) begin
        pages_q[free_num] <= tx_need;
      end
    end
  end

  // Host allocation request, completion flag and result.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      alloc_pending   <= 1'b0;
      alloc_bytes_q   <= '0;
      alloc_done_flag <= 1'b0;
      alloc_result    <= '0;
    end else if (clk_en) begin
      if (cmd_alloc_tx) begin
        alloc_pending <= 1'b1;
        alloc_bytes_q <= alloc_bytes;
      end else if (tx_grant) begin
        alloc_pending <= 1'b0;
      end
      if (tx_grant) begin
        alloc_done_flag <= 1'b1;
        alloc_result    <= free_num;
      end else if (alloc_done_clr) begin
        alloc_done_flag <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Transmit sequencing
  // ---------------------------------------------------------------------------
  assign tx_start = tx_state_q == TX_IDLE && !txq_empty && tx_enable_bit
                    && (full_duplex || defer_ok);
  // The status write yields to receive writes, which cannot be held off.
  assign tx_wr = tx_state_q == TX_STATUS && !rx_wr;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      tx_state_q <= TX_IDLE;
      tx_ok_q    <= 1'b0;
      tx_fatal_q <= 1'b0;
      tx_stat_q  <= '0;
    end else if (clk_en) begin
      unique case (tx_state_q)
        TX_IDLE: begin
          if (tx_start) begin
            tx_state_q <= TX_BUSY;
          end
        end
        TX_BUSY: begin
          if (tx_done) begin
            tx_state_q <= TX_STATUS;
            tx_ok_q    <= tx_ok;
            tx_fatal_q <= tx_fatal;
            tx_stat_q  <= tx_status;
          end
        end
        TX_STATUS: begin
          if (tx_wr) begin
            tx_state_q <= TX_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Receive sequencing
  // ---------------------------------------------------------------------------
  assign rx_wr = (rx_state_q == RX_DATA && rx_word_valid && !rx_drop_now)
                 || rx_state_q == RX_STAT || rx_state_q == RX_COUNT;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rx_state_q <= RX_IDLE;
      rx_pkt_q   <= '0;
      rx_off_q   <= '0;
      rx_crc_q   <= 1'b0;
      rx_stat_q  <= '0;
      rx_cnt_q   <= '0;
      rx_dropped <= 1'b0;
    end else if (clk_en) begin
      rx_dropped <= rx_drop_now || (rx_frame_start && rx_state_q == RX_IDLE
                                    && rx_enable_bit && !rx_new_ok);
      unique case (rx_state_q)
        RX_IDLE: begin
          if (rx_new_ok) begin
            rx_state_q <= RX_DATA;
            rx_pkt_q   <= free_num;
            rx_off_q   <= pbq_pkg::RX_FIRST_OFF;
          end else if (rx_frame_start && rx_enable_bit) begin
            rx_state_q <= RX_DROP;
          end
        end
        RX_DATA: begin
          if (rx_drop_now) begin
            rx_state_q <= rx_end ? RX_IDLE : RX_DROP;
          end else if (rx_end) begin
            rx_state_q <= RX_STAT;
            rx_crc_q   <= rx_crc_ok;
            rx_stat_q  <= rx_status;
            rx_cnt_q   <= rx_byte_count;
          end else if (rx_word_valid) begin
            rx_off_q <= rx_off_q + 1'b1;
          end
        end
        RX_STAT: begin
          rx_state_q <= RX_COUNT;
        end
        RX_COUNT: begin
          rx_state_q <= RX_IDLE;
        end
        RX_DROP: begin
          if (rx_end) begin
            rx_state_q <= RX_IDLE;
          end
        end
        default: begin
          rx_state_q <= RX_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Packet memory write port
  // ---------------------------------------------------------------------------
  // Each packet number owns a fixed slot; the word offset is its low address part.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      mem_we    <= 1'b0;
      mem_addr  <= '0;
      mem_wdata <= '0;
    end else if (clk_en) begin
      mem_we <= rx_wr || tx_wr;
      if (rx_state_q == RX_STAT) begin
        mem_addr  <= {rx_pkt_q, pbq_pkg::STAT_WORD};
        mem_wdata <= {16'h0000, rx_stat_q};
      end else if (rx_state_q == RX_COUNT) begin
        mem_addr  <= {rx_pkt_q, pbq_pkg::COUNT_WORD};
        mem_wdata <= {21'h00_0000, rx_cnt_q};
      end else if (rx_wr) begin
        mem_addr  <= {rx_pkt_q, rx_off_q[pbq_pkg::SLOT_W-1:0]};
        mem_wdata <= rx_word;
      end else if (tx_wr) begin
        mem_addr  <= {tx_pkt, pbq_pkg::STAT_WORD};
        mem_wdata <= {16'h0000, tx_stat_q};
      end
    end
  end
endmodule

// File: bench/packet_buffer_queue_manager_sva.sv
// Port-level checks of the packet buffer queue manager.
`timescale 1ns/1ps
module packet_buffer_queue_manager_sva (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        clk_en,
  input wire logic        tx_start,
  input wire logic        tx_enable_bit,
  input wire logic        full_duplex,
  input wire logic        defer_ok,
  input wire logic        tx_empty_flag,
  input wire logic        cmd_enqueue_tx,
  input wire logic        rx_pending_flag,
  input wire logic        rx_int_enable,
  input wire logic        alloc_done_flag,
  input wire logic        alloc_done_clr,
  input wire logic [9:0]  mem_pages,
  input wire logic [9:0]  free_pages,
  input wire logic        mem_we,
  input wire logic [14:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic        rx_frame_start,
  input wire logic        rx_enable_bit,
  input wire logic [9:0]  reserved_pages,
  input wire logic        rx_dropped
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_start_gated: assert property (tx_start |-> tx_enable_bit && (full_duplex || defer_ok))
    else $error("transmit started while held off");
  a_start_queued: assert property (tx_start |-> !tx_empty_flag)
    else $error("transmit started from an empty queue");
  a_enqueue_fills: assert property (cmd_enqueue_tx && clk_en |-> ##2 !tx_empty_flag)
    else $error("enqueue left the transmit queue empty");
  a_rx_masked: assert property (rx_pending_flag |-> rx_int_enable)
    else $error("receive flag high while masked");
  a_alloc_sticky: assert property (alloc_done_flag && !alloc_done_clr |=> alloc_done_flag)
    else $error("allocation flag dropped without clear");
  a_total_fixed: assert property (mem_pages == 10'h200)
    else $error("total memory size changed");
  a_free_bounded: assert property (free_pages <= mem_pages)
    else $error("free memory above total size");
  a_count_word: assert property (mem_we && mem_addr[8:0] == 9'h001 |-> mem_wdata[31:11] == 21'h0)
    else $error("byte count word has upper bits set");
  a_frame_refused: assert property (clk_en && rx_frame_start && rx_enable_bit
    && free_pages <= reserved_pages |=> rx_dropped)
    else $error("frame accepted into reserved memory");
endmodule
bind packet_buffer_queue_manager packet_buffer_queue_manager_sva u_sva (.*);

// File: bench/mac_tx_model.sv
// Behavioural transmit engine that answers every start after a fixed delay.
`timescale 1ns/1ps
module mac_tx_model (
  input  wire logic        clk_sys,
  input  wire logic        tx_start,
  input  wire logic [5:0]  tx_pkt,
  input  wire logic        fail,
  output logic             tx_done,
  output logic             tx_ok,
  output logic             tx_fatal,
  output logic [15:0]      tx_status
);
  logic       busy_q = 1'b0;
  logic [2:0] cnt_q = 3'h0;
  logic [5:0] pkt_q = 6'h00;
  initial {tx_done, tx_ok, tx_fatal, tx_status} = '0;
  // Result lines toggle while idle so a stale value is never mistaken for a real one.
  always @(posedge clk_sys) begin
    if (tx_start === 1'b1) begin
      busy_q  <= 1'b1;
      cnt_q   <= 3'h4;
      pkt_q   <= tx_pkt;
      tx_done <= 1'b0;
    end else if (busy_q && cnt_q == 3'h0) begin
      busy_q    <= 1'b0;
      tx_done   <= 1'b1;
      tx_ok     <= !fail;
      tx_fatal  <= fail;
      tx_status <= {10'h000, pkt_q};
    end else if (busy_q) begin
      cnt_q   <= cnt_q - 3'h1;
      tx_done <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      {tx_ok, tx_fatal, tx_status} <= ~{tx_ok, tx_fatal, tx_status};
    end
  end
endmodule

// File: bench/packet_buffer_queue_manager_test.sv
// Self-checking bench of the packet buffer queue manager.
`timescale 1ns/1ps
module packet_buffer_queue_manager_test;
  logic clk_sys, reset_n, clk_en, cmd_alloc_tx, alloc_done_clr, cmd_enqueue_tx, cmd_release;
  logic cmd_rx_pop_release, tx_int_ack, tx_enable_bit, rx_enable_bit, rx_int_enable;
  logic auto_release, full_duplex, defer_ok, rx_frame_start, rx_word_valid, rx_overrun, rx_end;
  logic rx_crc_ok, fail, alloc_done_flag, alloc_pending, tx_int_flag, tx_empty_flag, drop_seen;
  logic rx_pending_flag, tx_done, tx_ok, tx_fatal, tx_start, rx_dropped, mem_we;
  logic [10:0] alloc_bytes, rx_byte_count;
  logic [5:0]  packet_number_reg, alloc_result, tx_done_pkt, rx_head_pkt, tx_pkt, a2;
  logic [9:0]  reserved_pages, free_pages, mem_pages;
  logic [15:0] tx_status, rx_status;
  logic [31:0] rx_word, mem_wdata, w0, w1, w2;
  logic [14:0] mem_addr;
  int          n_errors, n_checks;
  logic [10:0] rows_b [4] = '{11'h001, 11'h100, 11'h101, 11'h7ff};
  logic [9:0]  rows_p [4] = '{10'h001, 10'h001, 10'h002, 10'h008};
  packet_buffer_queue_manager u_dut (.*);
  mac_tx_model u_mac (.*);
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    drop_seen <= (rx_dropped === 1'b1) || (drop_seen && rx_frame_start !== 1'b1);
    if (mem_we === 1'b1 && mem_addr[8:0] === 9'h000) w0 <= mem_wdata;
    if (mem_we === 1'b1 && mem_addr[8:0] === 9'h001) w1 <= mem_wdata;
    if (mem_we === 1'b1 && mem_addr[8:0] === 9'h002) {a2, w2} <= {mem_addr[14:9], mem_wdata};
  end
  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task step; @(posedge clk_sys); #1; endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task complete_run;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_hi(ref logic s);
    for (int i = 0; i < 200 && s !== 1'b1; i++) step();
    if (s !== 1'b1) begin
      n_errors++;
      complete_run();
    end
  endtask
  task alloc(input logic [10:0] b);
    alloc_bytes = b; cmd_alloc_tx = 1'b1; step(); cmd_alloc_tx = 1'b0;
    chk("alloc_pending", alloc_pending, 1);
    wait_hi(alloc_done_flag);
    packet_number_reg = alloc_result; alloc_done_clr = 1'b1; step(); alloc_done_clr = 1'b0; step();
  endtask
  task release_pkt; cmd_release = 1'b1; step(); cmd_release = 1'b0; repeat (3) step(); endtask
  task ack; tx_int_ack = 1'b1; step(); tx_int_ack = 1'b0; repeat (3) step(); endtask
  task send(input logic f, input logic ar);
    {tx_enable_bit, defer_ok, fail, auto_release} = {2'b10, f, ar};
    alloc(11'h040); cmd_enqueue_tx = 1'b1; step(); cmd_enqueue_tx = 1'b0; repeat (4) step();
    chk("tx_empty_held", tx_empty_flag, 0);
    chk("tx_pkt", tx_pkt, packet_number_reg);
    defer_ok = 1'b1; wait_hi(tx_done); repeat (6) step();
    chk("tx_empty_done", tx_empty_flag, 1);
    chk("tx_int", tx_int_flag, f | !ar);
  endtask
  task frame(input int nw, input logic ok, input logic [9:0] rsv, input logic ov);
    rx_frame_start = 1'b1; step(); {rx_frame_start, reserved_pages} = {1'b0, rsv};
    for (int i = 0; i < nw; i++) begin
      {rx_word_valid, rx_overrun} = {1'b1, ov && i == 1};
      rx_word = 32'h1234_0000 + 32'(i); step();
    end
    rx_overrun = 1'b0;
    {rx_word_valid, rx_crc_ok, rx_byte_count, rx_end} = {1'b0, ok, 11'(nw * 4), 1'b1};
    step(); rx_end = 1'b0; repeat (6) step();
  endtask
  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  initial begin
    {reset_n, cmd_alloc_tx, alloc_done_clr, cmd_enqueue_tx, cmd_release, cmd_rx_pop_release,
     tx_int_ack, tx_enable_bit, rx_enable_bit, rx_int_enable, auto_release, full_duplex,
     defer_ok, rx_frame_start, rx_word_valid, rx_overrun, rx_end, rx_crc_ok, fail} = '0;
    {alloc_bytes, rx_byte_count, packet_number_reg, reserved_pages, rx_word} = '0;
    {clk_en, rx_status, n_errors, n_checks} = {1'b1, 16'hc3c3, 64'h0};
    repeat (6) step();
    chk("rst_empty", tx_empty_flag, 1);
    chk("rst_free", {alloc_done_flag, tx_int_flag, free_pages}, 10'h200);
    reset_n = 1'b1; step();
    for (int i = 0; i < 4; i++) begin
      alloc(rows_b[i]);
      chk("free_alloc", free_pages, 10'h200 - rows_p[i]);
      release_pkt();
      chk("free_release", free_pages, 10'h200);
    end
    send(1'b0, 1'b0);
    chk("tx_done_pkt", tx_done_pkt, packet_number_reg);
    chk("tx_stat_word", w0, {26'h0, packet_number_reg});
    ack(); chk("tx_int_ack", tx_int_flag, 0);
    release_pkt(); send(1'b0, 1'b1);
    chk("auto_free", free_pages, 10'h200);
    send(1'b1, 1'b1); ack(); release_pkt();
    {rx_enable_bit, rx_int_enable} = 2'b11; frame(3, 1'b1, 10'h000, 1'b0);
    chk("rx_flag", rx_pending_flag, 1);
    chk("rx_pages", free_pages, 10'h1ff);
    chk("rx_data", w2, 32'h1234_0000);
    chk("rx_slot", a2, 6'h00);
    chk("rx_count", w1, 32'h0000_000c);
    chk("rx_stat", w0[15:0], 16'hc3c3);
    rx_int_enable = 1'b0; step(); chk("rx_masked", rx_pending_flag, 0);
    rx_int_enable = 1'b1; cmd_rx_pop_release = 1'b1; step(); cmd_rx_pop_release = 1'b0;
    repeat (3) step(); chk("rx_popped", {rx_pending_flag, free_pages}, 10'h200);
    frame(70, 1'b0, 10'h000, 1'b0);
    chk("bad_crc", {rx_pending_flag, free_pages}, 10'h200);
    frame(5, 1'b1, 10'h000, 1'b1);
    chk("overrun", {drop_seen, rx_pending_flag, free_pages}, 12'ha00);
    frame(70, 1'b1, 10'h200, 1'b0);
    chk("rsv_in_progress", {rx_pending_flag, free_pages}, 11'h5fe);
    frame(1, 1'b1, 10'h200, 1'b0);
    chk("reserve_drop", {drop_seen, rx_pending_flag}, 2'b11);
    clk_en = 1'b0; cmd_rx_pop_release = 1'b1; step(); {clk_en, cmd_rx_pop_release} = 2'b10; step();
    chk("frozen", {rx_pending_flag, free_pages}, 11'h5fe);
    reset_n = 1'b0; step();
    chk("rst_mid", {rx_pending_flag, tx_empty_flag, free_pages}, 12'h600);
    reset_n = 1'b1; step();
    complete_run();
  end
endmodule
